/* verilog/txdme_pkg.sv */
package txdme_pkg;
   // Channel count of the line interface
   localparam int unsigned CHANNELS = 12;
   // Silence threshold in transmit clock periods (nominal of 128 +/- 32)
   localparam int unsigned FAULT_PERIODS = 128;
   localparam int unsigned FAULT_MIN = 96;
   localparam int unsigned FAULT_MAX = 160;
   localparam int unsigned CNT_W = 8;
   // Reset values
   localparam logic ENABLE_BIT_RST = 1'h0;
   localparam logic FAULT_RST = 1'h0;
   // Host port timing modes
   typedef enum logic {
      TXDME_PORT_ASYNC = 1'b0,
      TXDME_PORT_SYNC  = 1'b1
   } txdme_port_mode_t;
endpackage

/* verilog/txdme_mon_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries one channel's monitor samples and fault result
interface txdme_mon_if;
   logic mon_pos;
   logic mon_neg;
   logic fault;
   modport top (output mon_pos, output mon_neg, input fault);
   modport mon (input mon_pos, input mon_neg, output fault);
endinterface
`default_nettype wire

/* verilog/txdme_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Per-channel silence watchdog on the monitor taps
module txdme_monitor
#(
   parameter int unsigned THRESHOLD = txdme_pkg::FAULT_PERIODS
) (
   input  wire logic    clk_in,   // Transmit line clock
   input  wire logic    rst_n_in, // Synchronous reset, active low
   txdme_mon_if.mon     mon       // Samples in, fault out
);
   import txdme_pkg::*;

   logic [CNT_W-1:0] count_reg;
   logic             pos_last_reg;
   logic             neg_last_reg;
   logic             fault_reg;
   logic             edge_seen;
   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(THRESHOLD);

   // Any change on either tap is a transition
   assign edge_seen = (mon.mon_pos != pos_last_reg) || (mon.mon_neg != neg_last_reg);

   // Previous tap levels
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pos_last_reg <= 1'h0;
         neg_last_reg <= 1'h0;
      end else begin
         pos_last_reg <= mon.mon_pos;
         neg_last_reg <= mon.mon_neg;
      end
   end

   // Silence counter, restarts on transitions and saturates at limit
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         count_reg <= '0; // (R12)
      end else if (edge_seen) begin
         count_reg <= '0; // (R11)
      end else if (count_reg != LIMIT) begin
         count_reg <= count_reg + 1'b1; // (R11)
      end
   end

   // Fault flag
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fault_reg <= FAULT_RST; // (R12)
      end else if (edge_seen) begin
         fault_reg <= 1'h0; // (R1) (R3)
      end else if (count_reg == LIMIT - 1'b1) begin
         fault_reg <= 1'h1; // (R2)
      end
   end

   assign mon.fault = fault_reg;
endmodule // txdme_monitor
`default_nettype wire

/* verilog/txdme_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Fault output stays low while monitor taps show transitions.
// (R2) Fault output rises after 128 +/- 32 silent transmit clock periods.
// (R3) Fault output falls again as soon as transitions return.
// (R4) Monitor is diagnostic only; transmitter works with taps unconnected.
// (R5) Each channel has its own independent transmitter on/off control.
// (R6) Driver enabled only when enable pin high and channel bit is 1.
// (R7) Off channel puts both line outputs in high impedance.
// (R8) With channel bit 1, enable pin switches the channel for switchover.
// (R9) Host port asynchronous when timing select low, synchronous when high.
// (R10) Host supplies bus clock as reference in synchronous timing; no bus clock input here, synchronous mode only sets port_mode_out.
// (R11) Counter restarts on transition, faults at one threshold in 96..160.
// (R12) Reset clears enable bits, fault output and monitor counter.
module txdme_top
#(
   parameter int unsigned NCH       = txdme_pkg::CHANNELS,
   parameter int unsigned THRESHOLD = txdme_pkg::FAULT_PERIODS
) (
   input  wire logic           clk_in,                   // Transmit line clock
   input  wire logic           rst_n_in,                 // Sync reset, active low
   input  wire logic [NCH-1:0] monitor_pos_in,           // Positive monitor taps
   input  wire logic [NCH-1:0] monitor_neg_in,           // Negative monitor taps
   input  wire logic           line_driver_enable_pin_in, // External driver enable
   input  wire logic [NCH-1:0] enable_bit_wr_in,         // Write strobe per channel
   input  wire logic [NCH-1:0] enable_bit_data_in,       // Value to write per channel
   input  wire logic [NCH-1:0] line_data_pos_in,         // Positive rail data
   input  wire logic [NCH-1:0] line_data_neg_in,         // Negative rail data
   input  wire logic           port_timing_sel_in,       // Host port timing select
   output logic [NCH-1:0]      line_driver_enable_bit_out, // Enable bit state
   output logic [NCH-1:0]      line_out_pos_out,         // Positive line output
   output logic [NCH-1:0]      line_out_pos_oe_out,      // Positive output enable
   output logic [NCH-1:0]      line_out_neg_out,         // Negative line output
   output logic [NCH-1:0]      line_out_neg_oe_out,      // Negative output enable
   output logic [NCH-1:0]      drive_fault_out,          // Drive fault, high on silence
   output var txdme_pkg::txdme_port_mode_t port_mode_out // Host port timing mode
);
   import txdme_pkg::*;

   logic             pin_s1_reg;
   logic             pin_s2_reg;
   logic             mode_s1_reg;
   logic             mode_s2_reg;
   logic [NCH-1:0]   mon_pos_s1_reg;
   logic [NCH-1:0]   mon_pos_s2_reg;
   logic [NCH-1:0]   mon_neg_s1_reg;
   logic [NCH-1:0]   mon_neg_s2_reg;
   logic [NCH-1:0]   enable_bit_reg;
   logic [NCH-1:0]   drive_on_reg;
   logic [NCH-1:0]   pos_reg;
   logic [NCH-1:0]   neg_reg;
   txdme_port_mode_t mode_reg;

   // Enable pin synchroniser; only the second stage feeds logic
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_s1_reg <= 1'h0;
         pin_s2_reg <= 1'h0;
      end else begin
         pin_s1_reg <= line_driver_enable_pin_in;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // Timing select synchroniser
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_s1_reg <= 1'h0;
         mode_s2_reg <= 1'h0;
      end else begin
         mode_s1_reg <= port_timing_sel_in;
         mode_s2_reg <= mode_s1_reg;
      end
   end

   // Monitor tap synchronisers, all channels side by side
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mon_pos_s1_reg <= '0;
         mon_pos_s2_reg <= '0;
         mon_neg_s1_reg <= '0;
         mon_neg_s2_reg <= '0;
      end else begin
         mon_pos_s1_reg <= monitor_pos_in;
         mon_pos_s2_reg <= mon_pos_s1_reg;
         mon_neg_s1_reg <= monitor_neg_in;
         mon_neg_s2_reg <= mon_neg_s1_reg;
      end
   end

   // Host port timing mode follows the select pin
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_reg <= TXDME_PORT_ASYNC;
      end else begin
         mode_reg <= mode_s2_reg ? TXDME_PORT_SYNC : TXDME_PORT_ASYNC; // (R9)
      end
   end

   // Per-channel enable bits, drivers and monitors
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         txdme_mon_if mif ();

         // Enable bit written only by its own strobe
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               enable_bit_reg[ch] <= ENABLE_BIT_RST; // (R12)
            end else if (enable_bit_wr_in[ch]) begin
               enable_bit_reg[ch] <= enable_bit_data_in[ch]; // (R5)
            end
         end

         // Driver on needs pin and bit; pin then switches it fast
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               drive_on_reg[ch] <= 1'h0;
            end else begin
               drive_on_reg[ch] <= pin_s2_reg & enable_bit_reg[ch]; // (R6) (R8)
            end
         end

         // Line data registered; independent of the monitor
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               pos_reg[ch] <= 1'h0;
               neg_reg[ch] <= 1'h0;
            end else begin
               pos_reg[ch] <= line_data_pos_in[ch]; // (R4)
               neg_reg[ch] <= line_data_neg_in[ch];
            end
         end

         assign mif.mon_pos = mon_pos_s2_reg[ch];
         assign mif.mon_neg = mon_neg_s2_reg[ch];
         assign drive_fault_out[ch] = mif.fault;

         txdme_monitor #(
            .THRESHOLD (THRESHOLD)
         ) u_mon (
            .clk_in   (clk_in),
            .rst_n_in (rst_n_in),
            .mon      (mif.mon)
         );
      end
   endgenerate

   // Outputs; enables low tri-state both line pins
   assign line_driver_enable_bit_out = enable_bit_reg;
   assign line_out_pos_out    = pos_reg;
   assign line_out_neg_out    = neg_reg;
   assign line_out_pos_oe_out = drive_on_reg; // (R7)
   assign line_out_neg_oe_out = drive_on_reg; // (R7)
   assign port_mode_out       = mode_reg;
endmodule // txdme_top
`default_nettype wire

/* sim/txdme_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Line driver and monitor resistor taps as seen from outside
module txdme_line_model #(
   parameter int unsigned NCH = 12
) (
   input  wire logic           clk_in,    // Transmit clock
   input  wire logic [NCH-1:0] pos_in,    // Positive line level
   input  wire logic [NCH-1:0] pos_oe_in, // Positive driver on
   input  wire logic [NCH-1:0] neg_in,    // Negative line level
   input  wire logic [NCH-1:0] neg_oe_in, // Negative driver on
   input  wire logic [NCH-1:0] stuck_in,  // Defective driver, taps frozen
   output logic      [NCH-1:0] mon_pos_out, // Positive tap
   output logic      [NCH-1:0] mon_neg_out  // Negative tap
);
   logic [NCH-1:0] last_pos = '0;
   logic [NCH-1:0] last_neg = '0;
   initial mon_pos_out = '1;
   initial mon_neg_out = '1;
   // Taps follow driven lines; released lines show the inverse of the last level
   // An unknown enable before reset counts as released, so no unknown reaches a tap
   always @(posedge clk_in) begin
      for (int i = 0; i < NCH; i++) begin
         if (stuck_in[i] !== 1'b1) begin
            mon_pos_out[i] <= (pos_oe_in[i] === 1'b1) ? pos_in[i] : ~last_pos[i];
            mon_neg_out[i] <= (neg_oe_in[i] === 1'b1) ? neg_in[i] : ~last_neg[i];
         end
         if (pos_oe_in[i] === 1'b1) last_pos[i] <= pos_in[i];
         if (neg_oe_in[i] === 1'b1) last_neg[i] <= neg_in[i];
      end
   end
endmodule // txdme_line_model
`default_nettype wire

/* sim/txdme_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the supervision block
module txdme_checker
#(
   parameter int unsigned NCH       = txdme_pkg::CHANNELS,
   parameter int unsigned THRESHOLD = txdme_pkg::FAULT_PERIODS
) (
   input wire logic             clk_in,
   input wire logic             rst_n_in,
   input wire logic [NCH-1:0]   monitor_pos_in,
   input wire logic [NCH-1:0]   monitor_neg_in,
   input wire logic             line_driver_enable_pin_in,
   input wire logic [NCH-1:0]   enable_bit_wr_in,
   input wire logic [NCH-1:0]   enable_bit_data_in,
   input wire logic             port_timing_sel_in,
   input wire logic [NCH-1:0]   line_driver_enable_bit_out,
   input wire logic [NCH-1:0]   line_out_pos_oe_out,
   input wire logic [NCH-1:0]   line_out_neg_oe_out,
   input wire logic [NCH-1:0]   drive_fault_out,
   input wire txdme_pkg::txdme_port_mode_t port_mode_out
);
   import txdme_pkg::*;

   localparam logic [7:0] RISE_AT = 8'(THRESHOLD + 4);
   localparam logic [7:0] QUIET_END = 8'(THRESHOLD - 2);
   logic [7:0] quiet_reg;
   // Silent clock cycles on channel 0 taps since their last change
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || $changed(monitor_pos_in[0]) || $changed(monitor_neg_in[0])) quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hff) quiet_reg <= quiet_reg + 8'h01;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_oe_needs_bit: assert property ((line_out_pos_oe_out & ~$past(line_driver_enable_bit_out)) == '0)
      else $error("driver on without enable bit");
   a_rails_off_together: assert property (line_out_pos_oe_out == line_out_neg_oe_out)
      else $error("rail enables differ");
   a_bit_takes_write: assert property (((line_driver_enable_bit_out ^ $past(enable_bit_data_in)) & $past(enable_bit_wr_in)) == '0)
      else $error("enable bit missed its write");
   a_bit_holds_alone: assert property (((line_driver_enable_bit_out ^ $past(line_driver_enable_bit_out)) & ~$past(enable_bit_wr_in)) == '0)
      else $error("enable bit changed unwritten");
   a_pin_low_off: assert property (!line_driver_enable_pin_in [*4] |-> line_out_pos_oe_out == '0)
      else $error("driver on with pin low");
   a_reset_clears: assert property (disable iff (1'b0) !rst_n_in |=> line_driver_enable_bit_out == '0 && drive_fault_out == '0 && line_out_pos_oe_out == '0)
      else $error("outputs not cleared by reset");
   a_fault_clears: assert property ($changed(monitor_pos_in[0]) |-> ##[1:3] !drive_fault_out[0])
      else $error("fault stayed after transition");
   a_fault_rises: assert property (quiet_reg == RISE_AT |-> drive_fault_out[0])
      else $error("fault missing after silence");
   a_fault_quiet: assert property (quiet_reg >= 8'h04 && quiet_reg < QUIET_END |-> !drive_fault_out[0])
      else $error("fault raised too early");
   a_mode_sync: assert property (port_timing_sel_in [*4] |-> port_mode_out == TXDME_PORT_SYNC)
      else $error("port mode not synchronous");
   c_fault: cover property (drive_fault_out[0]);
   c_driving: cover property (|line_out_pos_oe_out);
   c_sync: cover property (port_mode_out == TXDME_PORT_SYNC);
endmodule // txdme_checker
bind txdme_top txdme_checker #(.NCH(NCH), .THRESHOLD(THRESHOLD)) u_txdme_checker (.clk_in, .rst_n_in,
   .monitor_pos_in, .monitor_neg_in, .line_driver_enable_pin_in, .enable_bit_wr_in, .enable_bit_data_in,
   .port_timing_sel_in, .line_driver_enable_bit_out, .line_out_pos_oe_out, .line_out_neg_oe_out,
   .drive_fault_out, .port_mode_out);
`default_nettype wire

/* sim/tb_tx_drive_monitor_enable.sv */
`timescale 1ns/1ps
`default_nettype none
// Bench for the transmit supervision block
module tb_tx_drive_monitor_enable;
   import txdme_pkg::*;
   localparam int T = 8;
   logic clk_in = 0, rst_n_in = 0, pin = 0, sel = 0;
   logic [11:0] mp, mn, wr = '0, wd = '0, dp = '0, dn = '0, tog = '0, stuck = '0;
   logic [11:0] bit_o, po, poe, no, noe, flt;
   txdme_port_mode_t mode;
   int n_fail = 0, checks_done = 0, cyc = 0;
   always #5 clk_in = ~clk_in;
   // Rail data toggles on selected channels
   always @(negedge clk_in) begin
      dp <= dp ^ tog;
      dn <= dn ^ tog;
   end
   txdme_top #(.THRESHOLD(T)) u_txdme_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .monitor_pos_in(mp),
      .monitor_neg_in(mn), .line_driver_enable_pin_in(pin), .enable_bit_wr_in(wr),
      .enable_bit_data_in(wd), .line_data_pos_in(dp), .line_data_neg_in(dn), .port_timing_sel_in(sel),
      .line_driver_enable_bit_out(bit_o), .line_out_pos_out(po), .line_out_pos_oe_out(poe),
      .line_out_neg_out(no), .line_out_neg_oe_out(noe), .drive_fault_out(flt), .port_mode_out(mode));
   txdme_line_model u_txdme_line_model (.clk_in(clk_in), .pos_in(po), .pos_oe_in(poe), .neg_in(no),
      .neg_oe_in(noe), .stuck_in(stuck), .mon_pos_out(mp), .mon_neg_out(mn));
   task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_n(int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic write_bits(logic [11:0] m);
      wr = m;
      wd = m;
      wait_n(1);
      wr = '0;
   endtask
   task automatic t_enable;
      pin = 1;
      write_bits(12'h008);
      wait_n(3);
      chk("bit", 12'h008, bit_o);
      chk("oe", 12'h008, poe & noe);
      pin = 0;
      wait_n(4);
      chk("oe pin low", 12'h000, poe | noe);
      pin = 1;
      write_bits(12'h001);
      wait_n(4);
      chk("oe pin high", 12'h009, poe);
      $display("enable test done");
   endtask
   task automatic t_fault;
      tog = 12'h009;
      wait_n(T + 8);
      chk("fault live", 12'hff6, flt);
      tog = 12'h001;
      wait_n(T + 8);
      chk("fault silent", 12'hffe, flt);
      tog = 12'h009;
      wait_n(8);
      chk("fault back", 12'hff6, flt);
      stuck = 12'h008;
      wait_n(T + 8);
      chk("fault stuck", 12'hffe, flt);
      chk("oe stuck", 12'h009, poe);
      chk("rail pos", dp, po);
      chk("rail neg", dn, no);
      tog = 12'h000;
      wait_n(T + 8);
      chk("fault all", 12'hfff, flt);
      $display("fault test done");
   endtask
   task automatic t_mode;
      sel = 1;
      wait_n(4);
      chk("mode sync", 12'(TXDME_PORT_SYNC), 12'(mode));
      sel = 0;
      wait_n(4);
      chk("mode async", 12'(TXDME_PORT_ASYNC), 12'(mode));
      $display("mode test done");
   endtask
   task automatic t_reset;
      rst_n_in = 0;
      wait_n(2);
      chk("mid reset", 12'h000, bit_o | poe | flt);
      rst_n_in = 1;
      wait_n(4);
      chk("after reset", 12'h000, bit_o | poe | flt);
      $display("reset test done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Cycle ceiling against hangs
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      wait_n(12);
      chk("reset", 12'h000, bit_o | poe | flt);
      rst_n_in = 1;
      t_enable();
      t_fault();
      t_mode();
      t_reset();
      summarize();
   end
endmodule // tb_tx_drive_monitor_enable
`default_nettype wire
